// ---- rtl/irq_pkg.sv ----
// Constants, types and helpers shared by the interrupt flag and vector unit
package irq_pkg;

  // Program counter width seen by the core
  localparam int PC_W = 12;

  // Register byte offsets on the register bus
  localparam logic [4:0] OFF_TMR0 = 5'h00;
  localparam logic [4:0] OFF_TMR1 = 5'h04;
  localparam logic [4:0] OFF_TMR3 = 5'h08;
  localparam logic [4:0] OFF_CTRL = 5'h0C;
  localparam logic [4:0] OFF_HALL = 5'h10;
  localparam logic [4:0] OFF_EDGE = 5'h14;
  localparam logic [4:0] OFF_STAT = 5'h18;

  // Timer match register fields
  localparam int TMR_AF_BIT = 5;
  localparam int TMR_PF_BIT = 4;
  localparam int TMR_AE_BIT = 1;
  localparam int TMR_PE_BIT = 0;

  // Control register fields
  localparam int CTRL_GIE_BIT  = 0;
  localparam int CTRL_HGE_BIT  = 1;
  localparam int CTRL_EXTE_BIT = 2;
  localparam int CTRL_FLTE_BIT = 3;
  localparam int CTRL_HGF_BIT  = 4;
  localparam int CTRL_EXTF_BIT = 5;
  localparam int CTRL_FLTF_BIT = 6;
  localparam int CTRL_TGF_BIT  = 7;
  localparam int CTRL_TGE_BIT  = 8;

  // Hall register fields: flags at 6..4, enables at 2..0
  localparam int HALL_F_LSB = 4;
  localparam int HALL_E_LSB = 0;

  // Edge select register fields
  localparam int EDGE_HALL_LSB = 0;
  localparam int EDGE_EXT_LSB  = 2;
  localparam int EDGE_FLT_LSB  = 4;

  // Values after reset
  localparam logic [7:0] TMR_RST  = 8'h00;
  localparam logic [1:0] EDGE_RST = 2'h0;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Edge select encoding
  typedef enum logic [1:0] {
    EDGE_OFF  = 2'h0,
    EDGE_RISE = 2'h1,
    EDGE_FALL = 2'h2,
    EDGE_BOTH = 2'h3
  } edge_sel_t;

  // Serviced source, one-hot
  typedef enum logic [3:0] {
    SRC_NONE = 4'h0,
    SRC_EXT  = 4'h1,
    SRC_FLT  = 4'h2,
    SRC_HALL = 4'h4,
    SRC_TMR  = 4'h8
  } irq_src_t;

  // Vector request to the program sequencer
  typedef struct packed {
    logic              take;
    irq_src_t          src;
    logic [PC_W-1:0]   vector;
    logic [PC_W-1:0]   push_addr;
  } irq_take_t;

  // Selected transition seen between previous and current level
  function automatic logic edge_hit(input logic cur, input logic prev,
                                    input logic [1:0] sel);
    edge_hit = (cur & ~prev & sel[0]) | (~cur & prev & sel[1]);
  endfunction

endpackage

// ---- rtl/irq_vector_unit.sv ----
// Interrupt flag, enable and vectoring unit with AXI4-Lite registers
//
// Operation
// - timer0 register: flags bits 5,4, enables 1,0
// - timer1 register uses the same layout
// - timer3 register uses the same layout
// - unused bits read zero, all reset zero
// - events set flags; enable gates vector jump
// - global enable low blocks all vectoring
// - take pushes next PC, loads vector
// - return instruction pops the saved PC
// - entry clears global enable; flags keep recording
// - full stack blocks acknowledge until pop
// - simultaneous requests served by fixed priority
// - any flag setting raises wake request
// - Hall flags set on selected filtered edge
// - Hall vector needs global, group, channel enables
// - Hall service clears group flag only
// - external flag set on selected pin edge
// - external service vectors and clears its flag
// - filter input flag on two-bit edge select
// - filter input service vectors and clears flag
// - edge codes: off, rise, fall, both
// - group flag set by member; service clears group
//
// The implementer's own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/10ps
module irq_vector_unit
  import irq_pkg::*;
#(
  parameter logic [PC_W-1:0] VEC_EXT  = 12'h004,
  parameter logic [PC_W-1:0] VEC_FLT  = 12'h008,
  parameter logic [PC_W-1:0] VEC_HALL = 12'h00C,
  parameter logic [PC_W-1:0] VEC_TMR  = 12'h010
) (
  input  wire logic             clk,
  input  wire logic             reset,
  // AXI4-Lite slave
  input  wire logic [4:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [4:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  // Event sources
  input  wire logic             filtered_hall_a,
  input  wire logic             filtered_hall_b,
  input  wire logic             filtered_hall_c,
  input  wire logic             ext_pin,
  input  wire logic             filtered_input_pin,
  input  wire logic [2:0]       tmr_cmpa_match,
  input  wire logic [2:0]       tmr_cmpp_match,
  // Program sequencer side
  input  wire logic [PC_W-1:0]  core_next_pc,
  input  wire logic             stack_full,
  input  wire logic             return_from_irq,
  output irq_take_t             irq_take,
  output logic                  stack_pop,
  output logic                  wake_req
);

  // Register state
  logic [2:0] tmr_cmpa_flag_reg, tmr_cmpp_flag_reg;
  logic [2:0] tmr_cmpa_en_reg, tmr_cmpp_en_reg;
  logic [2:0] hall_flag_reg, hall_en_reg;
  logic       global_irq_en_reg, hall_group_en_reg, tmr_group_en_reg;
  logic       ext_pin_en_reg, filtered_input_en_reg;
  logic       hall_group_flag_reg, tmr_group_flag_reg;
  logic       ext_pin_flag_reg, filtered_input_flag_reg;
  logic [1:0] hall_edge_select_reg, ext_pin_edge_select_reg;
  logic [1:0] filt_edge_sel_reg;
  logic [2:0] hall_prev_reg;
  logic       ext_prev_reg, filt_prev_reg;

  // Bus state
  logic [4:0]  awaddr_reg;
  logic        aw_have_reg, w_have_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;

  // Combinational terms
  logic        wr_fire, wr_b0, wr_b1;
  logic [2:0]  hall_level, hall_set, tmr_a_set, tmr_p_set;
  logic        ext_set, filt_set, hall_grp_set, tmr_grp_set;
  logic        pend_ext, pend_flt, pend_hall, pend_tmr, can_take;
  irq_src_t    pick;
  logic [31:0] rd_mux;
  logic        rd_hit;

  assign hall_level = {filtered_hall_c, filtered_hall_b, filtered_hall_a};

  // Write path: address and data are taken in either order
  assign s_axi_awready = ~aw_have_reg;
  assign s_axi_wready  = ~w_have_reg;
  assign wr_fire = aw_have_reg & w_have_reg & ~s_axi_bvalid;
  assign wr_b0   = wr_fire & wstrb_reg[0];
  assign wr_b1   = wr_fire & wstrb_reg[1];

  // Write address and data holding
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      aw_have_reg <= 1'b0;
      w_have_reg  <= 1'b0;
      awaddr_reg  <= 5'h00;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
    end else begin
      if (s_axi_awvalid && !aw_have_reg) begin
        aw_have_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_have_reg <= 1'b0;
      end
      if (s_axi_wvalid && !w_have_reg) begin
        w_have_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_have_reg <= 1'b0;
      end
    end
  end

  // Write response; unmapped or status offsets answer with an error
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (awaddr_reg <= OFF_EDGE && awaddr_reg[1:0] == 2'h0)
                      ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Edge detectors on the sampled inputs
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hall_prev_reg <= 3'h0;
      ext_prev_reg  <= 1'b0;
      filt_prev_reg <= 1'b0;
    end else begin
      hall_prev_reg <= hall_level;
      ext_prev_reg  <= ext_pin;
      filt_prev_reg <= filtered_input_pin;
    end
  end

  // Set terms per source: one-cycle edge pulses, timer match inputs passed through as they are
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_hall_edge
      assign hall_set[g] = edge_hit(hall_level[g], hall_prev_reg[g],
                                    hall_edge_select_reg);
    end
  endgenerate
  assign ext_set  = edge_hit(ext_pin, ext_prev_reg,
                             ext_pin_edge_select_reg);
  assign filt_set = edge_hit(filtered_input_pin, filt_prev_reg,
                             filt_edge_sel_reg);
  assign tmr_a_set = tmr_cmpa_match;
  assign tmr_p_set = tmr_cmpp_match;

  // Group requests only from enabled members
  assign hall_grp_set = |(hall_set & hall_en_reg);
  assign tmr_grp_set  = |(tmr_a_set & tmr_cmpa_en_reg)
                      | |(tmr_p_set & tmr_cmpp_en_reg);

  // Pending requests and fixed-priority pick
  assign pend_ext  = ext_pin_flag_reg & ext_pin_en_reg;
  assign pend_flt  = filtered_input_flag_reg & filtered_input_en_reg;
  assign pend_hall = hall_group_flag_reg & hall_group_en_reg;
  assign pend_tmr  = tmr_group_flag_reg & tmr_group_en_reg;
  assign can_take  = global_irq_en_reg & ~stack_full;

  always_comb begin
    pick = SRC_NONE;
    if (can_take) begin
      if (pend_ext) begin
        pick = SRC_EXT;
      end else if (pend_flt) begin
        pick = SRC_FLT;
      end else if (pend_hall) begin
        pick = SRC_HALL;
      end else if (pend_tmr) begin
        pick = SRC_TMR;
      end
    end
  end

  // Timer match flags and enables, one register per timer
  generate
    for (g = 0; g < 3; g++) begin : g_tmr
      logic [4:0] off;
      assign off = (g == 0) ? OFF_TMR0 : (g == 1) ? OFF_TMR1 : OFF_TMR3;
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          tmr_cmpa_flag_reg[g] <= TMR_RST[TMR_AF_BIT];
          tmr_cmpp_flag_reg[g] <= TMR_RST[TMR_PF_BIT];
          tmr_cmpa_en_reg[g]   <= TMR_RST[TMR_AE_BIT];
          tmr_cmpp_en_reg[g]   <= TMR_RST[TMR_PE_BIT];
        end else begin
          if (wr_b0 && awaddr_reg == off) begin
            tmr_cmpa_flag_reg[g] <= wdata_reg[TMR_AF_BIT] | tmr_a_set[g];
            tmr_cmpp_flag_reg[g] <= wdata_reg[TMR_PF_BIT] | tmr_p_set[g];
            tmr_cmpa_en_reg[g]   <= wdata_reg[TMR_AE_BIT];
            tmr_cmpp_en_reg[g]   <= wdata_reg[TMR_PE_BIT];
          end else begin
            tmr_cmpa_flag_reg[g] <= tmr_cmpa_flag_reg[g] | tmr_a_set[g];
            tmr_cmpp_flag_reg[g] <= tmr_cmpp_flag_reg[g] | tmr_p_set[g];
          end
        end
      end
    end
  endgenerate

  // Hall member flags: only software clears them
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hall_flag_reg <= 3'h0;
      hall_en_reg   <= 3'h0;
    end else if (wr_b0 && awaddr_reg == OFF_HALL) begin
      hall_flag_reg <= wdata_reg[HALL_F_LSB +: 3] | hall_set;
      hall_en_reg   <= wdata_reg[HALL_E_LSB +: 3];
    end else begin
      hall_flag_reg <= hall_flag_reg | hall_set;
    end
  end

  // Edge select fields
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hall_edge_select_reg    <= EDGE_RST;
      ext_pin_edge_select_reg <= EDGE_RST;
      filt_edge_sel_reg       <= EDGE_RST;
    end else if (wr_b0 && awaddr_reg == OFF_EDGE) begin
      hall_edge_select_reg    <= wdata_reg[EDGE_HALL_LSB +: 2];
      ext_pin_edge_select_reg <= wdata_reg[EDGE_EXT_LSB +: 2];
      filt_edge_sel_reg       <= wdata_reg[EDGE_FLT_LSB +: 2];
    end
  end

  // Control enables; entry to service drops the global enable
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      global_irq_en_reg     <= 1'b0;
      hall_group_en_reg     <= 1'b0;
      ext_pin_en_reg        <= 1'b0;
      filtered_input_en_reg <= 1'b0;
      tmr_group_en_reg      <= 1'b0;
    end else begin
      if (pick != SRC_NONE) begin
        global_irq_en_reg <= 1'b0;
      end else if (wr_b0 && awaddr_reg == OFF_CTRL) begin
        global_irq_en_reg <= wdata_reg[CTRL_GIE_BIT];
      end
      if (wr_b0 && awaddr_reg == OFF_CTRL) begin
        hall_group_en_reg     <= wdata_reg[CTRL_HGE_BIT];
        ext_pin_en_reg        <= wdata_reg[CTRL_EXTE_BIT];
        filtered_input_en_reg <= wdata_reg[CTRL_FLTE_BIT];
      end
      if (wr_b1 && awaddr_reg == OFF_CTRL) begin
        tmr_group_en_reg <= wdata_reg[CTRL_TGE_BIT];
      end
    end
  end

  // Auto-cleared request flags; a new event beats any clear
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hall_group_flag_reg     <= 1'b0;
      ext_pin_flag_reg        <= 1'b0;
      filtered_input_flag_reg <= 1'b0;
      tmr_group_flag_reg      <= 1'b0;
    end else if (wr_b0 && awaddr_reg == OFF_CTRL) begin
      hall_group_flag_reg     <= wdata_reg[CTRL_HGF_BIT] | hall_grp_set;
      ext_pin_flag_reg        <= wdata_reg[CTRL_EXTF_BIT] | ext_set;
      filtered_input_flag_reg <= wdata_reg[CTRL_FLTF_BIT] | filt_set;
      tmr_group_flag_reg      <= wdata_reg[CTRL_TGF_BIT] | tmr_grp_set;
    end else begin
      hall_group_flag_reg <= (hall_group_flag_reg & (pick != SRC_HALL))
                             | hall_grp_set;
      ext_pin_flag_reg    <= (ext_pin_flag_reg & (pick != SRC_EXT))
                             | ext_set;
      filtered_input_flag_reg <= (filtered_input_flag_reg
                                  & (pick != SRC_FLT)) | filt_set;
      tmr_group_flag_reg  <= (tmr_group_flag_reg & (pick != SRC_TMR))
                             | tmr_grp_set;
    end
  end

  // Vector request, stack pop and wake outputs
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_take  <= '0;
      stack_pop <= 1'b0;
      wake_req  <= 1'b0;
    end else begin
      irq_take.take      <= (pick != SRC_NONE);
      irq_take.src       <= pick;
      irq_take.push_addr <= core_next_pc;
      case (pick)
        SRC_EXT:  irq_take.vector <= VEC_EXT;
        SRC_FLT:  irq_take.vector <= VEC_FLT;
        SRC_HALL: irq_take.vector <= VEC_HALL;
        SRC_TMR:  irq_take.vector <= VEC_TMR;
        default:  irq_take.vector <= irq_take.vector;
      endcase
      stack_pop <= return_from_irq;
      wake_req  <= |{hall_set, ext_set, filt_set, tmr_a_set,
                     tmr_p_set};
    end
  end

  // Read data selection
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      OFF_TMR0: rd_mux[5:0] = {tmr_cmpa_flag_reg[0], tmr_cmpp_flag_reg[0],
                               2'h0, tmr_cmpa_en_reg[0],
                               tmr_cmpp_en_reg[0]};
      OFF_TMR1: rd_mux[5:0] = {tmr_cmpa_flag_reg[1], tmr_cmpp_flag_reg[1],
                               2'h0, tmr_cmpa_en_reg[1],
                               tmr_cmpp_en_reg[1]};
      OFF_TMR3: rd_mux[5:0] = {tmr_cmpa_flag_reg[2], tmr_cmpp_flag_reg[2],
                               2'h0, tmr_cmpa_en_reg[2],
                               tmr_cmpp_en_reg[2]};
      OFF_CTRL: rd_mux[8:0] = {tmr_group_en_reg, tmr_group_flag_reg,
                               filtered_input_flag_reg, ext_pin_flag_reg,
                               hall_group_flag_reg, filtered_input_en_reg,
                               ext_pin_en_reg, hall_group_en_reg,
                               global_irq_en_reg};
      OFF_HALL: rd_mux[6:0] = {hall_flag_reg, 1'b0, hall_en_reg};
      OFF_EDGE: rd_mux[5:0] = {filt_edge_sel_reg, ext_pin_edge_select_reg,
                               hall_edge_select_reg};
      OFF_STAT: rd_mux[5:0] = {stack_full, irq_take.take, pend_tmr,
                               pend_hall, pend_flt, pend_ext};
      default:  rd_hit = 1'b0;
    endcase
  end

  // Read channel: one read in flight
  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // irq_vector_unit

// ---- tb/cpu_seq_model.sv ----
// Behavioural program sequencer with a shallow return stack
`timescale 1ns/10ps
module cpu_seq_model
  import irq_pkg::*;
#(
  parameter int DEPTH = 1
) (
  input  wire logic            clk,
  input  wire logic            reset,
  input  wire irq_take_t       irq_take,
  input  wire logic            stack_pop,
  input  wire logic            ret_cmd,
  output logic [PC_W-1:0]      core_next_pc,
  output logic                 stack_full,
  output logic                 return_from_irq
);
  logic [PC_W-1:0] stack_q[$];
  logic [PC_W-1:0] pc_reg;
  int              level;

  // Program counter steps; a take pushes and jumps, a pop returns
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      stack_q.delete();
      pc_reg <= 12'h100;
      level <= 0;
      return_from_irq <= 1'b0;
    end else begin
      return_from_irq <= ret_cmd && (level > 0);
      if (irq_take.take) begin
        stack_q.push_back(irq_take.push_addr);
        pc_reg <= irq_take.vector;
      end else if (stack_pop && stack_q.size() > 0) begin
        pc_reg <= stack_q.pop_back();
      end else begin
        pc_reg <= pc_reg + 12'h001;
      end
      level <= stack_q.size();
    end
  end

  // Next instruction address and stack limit seen by the unit
  assign core_next_pc = pc_reg + 12'h001;
  assign stack_full = (level == DEPTH);
endmodule // cpu_seq_model

// ---- tb/irq_vector_unit_chk.sv ----
// Port-level assertions for the interrupt flag and vector unit
`timescale 1ns/10ps
module irq_vector_unit_chk
  import irq_pkg::*;
#(
  parameter logic [PC_W-1:0] VEC_EXT  = 12'h004,
  parameter logic [PC_W-1:0] VEC_HALL = 12'h00C
) (
  input wire logic            clk,
  input wire logic            reset,
  input wire logic [1:0]      s_axi_bresp,
  input wire logic            s_axi_bvalid,
  input wire logic            s_axi_rvalid,
  input wire logic            s_axi_rready,
  input wire logic [2:0]      tmr_cmpa_match,
  input wire logic [2:0]      tmr_cmpp_match,
  input wire logic [PC_W-1:0] core_next_pc,
  input wire logic            stack_full,
  input wire logic            return_from_irq,
  input wire irq_take_t       irq_take,
  input wire logic            stack_pop,
  input wire logic            wake_req
);
  // One clock domain, checks muted in reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // Vector request pulse, its payload and its preconditions
  property p_take_once; irq_take.take |=> !irq_take.take; endproperty
  a_take_once: assert property (p_take_once)
    else $error("take pulse longer than one cycle");
  property p_full; irq_take.take |-> !$past(stack_full); endproperty
  a_full: assert property (p_full)
    else $error("take while stack full");
  property p_push;
    irq_take.take |-> irq_take.push_addr == $past(core_next_pc);
  endproperty
  a_push: assert property (p_push)
    else $error("pushed address wrong");
  property p_onehot; irq_take.take |-> $onehot(irq_take.src); endproperty
  a_onehot: assert property (p_onehot)
    else $error("more than one source served");
  property p_vec_ext;
    irq_take.take && irq_take.src == SRC_EXT |-> irq_take.vector == VEC_EXT;
  endproperty
  a_vec_ext: assert property (p_vec_ext)
    else $error("external vector wrong");
  property p_vec_hall;
    irq_take.take && irq_take.src == SRC_HALL |->
      irq_take.vector == VEC_HALL;
  endproperty
  a_vec_hall: assert property (p_vec_hall)
    else $error("hall vector wrong");
  // Return path, wake request and read data release
  property p_pop; return_from_irq |=> stack_pop; endproperty
  a_pop: assert property (p_pop)
    else $error("no pop after return");
  property p_wake;
    (tmr_cmpa_match != 3'h0) || (tmr_cmpp_match != 3'h0) |=> wake_req;
  endproperty
  a_wake: assert property (p_wake)
    else $error("no wake after timer event");
  property p_rdone; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_rdone: assert property (p_rdone)
    else $error("read data not released");

  // Main scenarios reached
  c_flt: cover property (irq_take.take && irq_take.src == SRC_FLT);
  c_err: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
  c_ret: cover property (stack_full && return_from_irq);
endmodule // irq_vector_unit_chk

// ---- tb/tb_top.sv ----
// Self-checking bench for the interrupt flag and vector unit
`timescale 1ns/10ps
`define CHK(n, e, g) begin \
  tests_run++; \
  if ((g) !== (e)) begin \
    miscompares++; \
    $display("Error %s expected %0h seen %0h", n, e, g); \
  end \
end
module tb_top
  import irq_pkg::*;
;
  logic        clk, reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, ext_pin, filtered_input_pin;
  logic        filtered_hall_a, filtered_hall_b, filtered_hall_c, ret_cmd;
  logic [4:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_v, d;
  logic [3:0]  s_axi_wstrb;
  logic [2:0]  tmr_cmpa_match, tmr_cmpp_match;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, stack_full, return_from_irq, stack_pop;
  logic        wake_req, f;
  logic [11:0] core_next_pc, e;
  irq_take_t   irq_take;
  logic [11:0] exp_q[$];
  int          miscompares, tests_run, cyc, seed;
  // Vectors the bench gives the unit and expects to see taken
  localparam logic [11:0] EXP_VEC_EXT  = 12'h004;
  localparam logic [11:0] EXP_VEC_FLT  = 12'h008;
  localparam logic [11:0] EXP_VEC_HALL = 12'h00C;
  localparam logic [11:0] EXP_VEC_TMR  = 12'h010;

  irq_vector_unit #(.VEC_EXT(EXP_VEC_EXT), .VEC_FLT(EXP_VEC_FLT),
    .VEC_HALL(EXP_VEC_HALL), .VEC_TMR(EXP_VEC_TMR)) i_irq_vector_unit (
    .clk, .reset, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .filtered_hall_a, .filtered_hall_b, .filtered_hall_c, .ext_pin,
    .filtered_input_pin, .tmr_cmpa_match, .tmr_cmpp_match, .core_next_pc,
    .stack_full, .return_from_irq, .irq_take, .stack_pop, .wake_req);
  cpu_seq_model i_cpu_seq_model (.clk, .reset, .irq_take, .stack_pop,
    .ret_cmd, .core_next_pc, .stack_full, .return_from_irq);

  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      complete_run();
    end
  end

  // Every take is matched against the next predicted vector
  always @(posedge clk) begin
    if (!reset && irq_take.take === 1'b1) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 12'hFFF;
      `CHK("vector", e, irq_take.vector)
    end
  end

  // Register write; address and data released each when taken
  task automatic wr(input logic [4:0] a, input logic [31:0] v,
                    input logic [1:0] er = RESP_OKAY);
    logic ca, cw, cb;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    cb = 1'b0;
    while (!cb) begin
      @(negedge clk);
      ca = s_axi_awvalid & s_axi_awready;
      cw = s_axi_wvalid & s_axi_wready;
      cb = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge clk);
      if (ca) s_axi_awvalid <= 1'b0;
      if (cw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    `CHK("bresp", er, rsp)
  endtask

  // Register read compared with the predicted word
  task automatic rd(input logic [4:0] a, input logic [31:0] ed,
                    input logic [1:0] er = RESP_OKAY);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    @(negedge clk);
    while (!s_axi_arready) @(negedge clk);
    @(posedge clk);
    s_axi_arvalid <= 1'b0;
    @(negedge clk);
    while (!s_axi_rvalid) @(negedge clk);
    rd_v = s_axi_rdata;
    rsp = s_axi_rresp;
    @(posedge clk);
    s_axi_rready <= 1'b0;
    `CHK("rdata", ed, rd_v)
    `CHK("rresp", er, rsp)
  endtask

  // Drive every level input to one value and let flags settle
  task automatic pins(input logic v);
    @(posedge clk);
    {filtered_hall_a, filtered_hall_b, filtered_hall_c} <= {3{v}};
    ext_pin <= v;
    filtered_input_pin <= v;
    repeat (4) @(posedge clk);
  endtask

  // Software return from the running service routine
  task automatic ret();
    @(posedge clk);
    ret_cmd <= 1'b1;
    @(posedge clk);
    ret_cmd <= 1'b0;
    repeat (8) @(posedge clk);
  endtask

  task automatic complete_run();
    if (miscompares == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Main sequence
  initial begin
    seed = 9702;
    reset = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, ret_cmd} = '0;
    {s_axi_arvalid, s_axi_rready, ext_pin, filtered_input_pin} = '0;
    {filtered_hall_a, filtered_hall_b, filtered_hall_c} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {tmr_cmpa_match, tmr_cmpp_match} = '0;
    s_axi_wstrb = 4'hF;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 7; i++) rd(5'(i * 4), 32'h0);
    for (int i = 0; i < 3; i++) begin
      d = $random(seed);
      wr(5'(i * 4), d);
      rd(5'(i * 4), d & 32'h33);
      wr(5'(i * 4), 32'h0);
    end
    rd(5'h1C, 32'h0, RESP_SLVERR);
    wr(OFF_STAT, 32'hFF, RESP_SLVERR);
    // Timer event with its enable low only raises the flag
    @(posedge clk);
    tmr_cmpa_match <= 3'h4;
    @(posedge clk);
    tmr_cmpa_match <= 3'h0;
    rd(OFF_TMR3, 32'h20);
    wr(OFF_TMR3, 32'h0);
    // Each edge code, rising then falling, global enable off
    for (int c = 0; c < 4; c++) begin
      for (int v = 1; v >= 0; v--) begin
        wr(OFF_CTRL, 32'h0);
        wr(OFF_HALL, 32'h0);
        wr(OFF_EDGE, 32'(c * 21));
        pins(v == 1);
        f = (v == 1) ? c[0] : c[1];
        rd(OFF_CTRL, {25'h0, f, f, 5'h0});
        rd(OFF_HALL, {25'h0, {3{f}}, 4'h0});
      end
    end
    // Two requests at once, then a full stack holds the second
    wr(OFF_EDGE, 32'h14);
    wr(OFF_CTRL, 32'hD);
    exp_q.push_back(EXP_VEC_EXT);
    pins(1'b1);
    rd(OFF_CTRL, 32'h4C);
    wr(OFF_CTRL, 32'h4D);
    repeat (8) @(posedge clk);
    exp_q.push_back(EXP_VEC_FLT);
    ret();
    rd(OFF_CTRL, 32'hC);
    ret();
    // Hall group: group flag cleared on service, members stay
    pins(1'b0);
    wr(OFF_EDGE, 32'h1);
    wr(OFF_HALL, 32'h1);
    wr(OFF_CTRL, 32'h3);
    exp_q.push_back(EXP_VEC_HALL);
    pins(1'b1);
    rd(OFF_CTRL, 32'h2);
    rd(OFF_HALL, 32'h71);
    ret();
    // Timer group through its own enable
    wr(OFF_TMR0, 32'h1);
    wr(OFF_CTRL, 32'h101);
    exp_q.push_back(EXP_VEC_TMR);
    @(posedge clk);
    tmr_cmpp_match <= 3'h1;
    @(posedge clk);
    tmr_cmpp_match <= 3'h0;
    repeat (4) @(posedge clk);
    rd(OFF_TMR0, 32'h11);
    rd(OFF_CTRL, 32'h100);
    ret();
    `CHK("pending", 0, exp_q.size())
    complete_run();
  end
endmodule // tb_top

bind irq_vector_unit irq_vector_unit_chk #(.VEC_EXT(VEC_EXT),
  .VEC_HALL(VEC_HALL)) i_irq_vector_unit_chk (.clk, .reset, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_rvalid, .s_axi_rready, .tmr_cmpa_match,
  .tmr_cmpp_match, .core_next_pc, .stack_full, .return_from_irq,
  .irq_take, .stack_pop, .wake_req);
